// ==== rtl/drh_device_end.sv ====
// device end: dma request generation and ram data access
// Functional notes
// RULE_01: first request 4 to 5 Tarb after pointer
// RULE_02: burst gate timeout re-requests after 7/15 Txtl
// RULE_03: burst mode re-requests on burst refresh input
// RULE_04: refresh never low while acknowledge low
// RULE_05: non-burst re-requests after each strobe ends
// RULE_06: request drops when a strobe becomes active
// RULE_07: terminal count with write ends the transfer
// RULE_08: Tarb is Topr, doubled with slow arbitration
// RULE_09: software sets slow arbitration above 5 Mbps
// RULE_10: intel mode uses write and read lines
// RULE_11: motorola data strobe, direction picks write/read
// RULE_12: controller spaces writes at least 4 Tarb
// RULE_13: reads 4 Tarb, plus 30 ns when slow
// RULE_14: chip select inactive around acknowledge
// RULE_15: pointer reads wait 5 Tarb after dma
// RULE_16: each dma access moves one byte, pointer advances
`default_nettype none
module drh_device_end (
   input wire logic i_clk,
   input wire logic i_reset_n,
   drh_if.dev bus,
   input wire logic i_host_ptr_wr,
   input wire logic [drh_pkg::ADDR_W-1:0] i_host_ptr,
   input wire logic i_host_we,
   input wire logic [drh_pkg::ADDR_W-1:0] i_host_addr,
   input wire logic [drh_pkg::DATA_W-1:0] i_host_wdata,
   input wire logic i_motorola_mode,
   input wire logic i_burst_mode,
   input wire logic i_gate_timer_length_bit,
   input wire logic i_slow_arbitration_bit,
   input wire logic i_clock_multiplier_hi_bit,
   input wire logic i_clock_multiplier_lo_bit,
   output logic [drh_pkg::ADDR_W-1:0] o_dma_ptr,
   output logic [drh_pkg::DATA_W-1:0] o_host_rdata,
   output logic o_active,
   output logic o_done
);
   import drh_pkg::*;

   typedef enum logic [2:0] {DEV_IDLE, DEV_ARM, DEV_REQ, DEV_XFER, DEV_WAIT} drh_dev_st_t;

   typedef struct packed {
      drh_dev_st_t st;
      logic [DEV_PIN_W-1:0] s1;
      logic [DEV_PIN_W-1:0] s2;
      logic [DEV_PIN_W-1:0] s3;
      logic [DEV_PIN_W-1:0] filt;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] ptr;
      logic [DATA_W-1:0] wdat;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] host_rdata;
      logic is_wr;
      logic end_x;
      logic req;
      logic doe;
      logic active;
      logic done;
   } drh_dev_state_t;

   localparam drh_dev_state_t DEV_RST = '{st: DEV_IDLE, s1: DEV_PIN_IDLE, s2: DEV_PIN_IDLE,
      s3: DEV_PIN_IDLE, filt: DEV_PIN_IDLE, ptr: PTR_RESET, default: '0};

   drh_dev_state_t q, n;
   logic [DATA_W-1:0] ram [RAM_DEPTH];
   logic [DEV_PIN_W-1:0] pins;
   logic [7:0] topr;
   logic [8:0] tarb;
   logic [CNT_W-1:0] first_lim, gate_lim;
   logic dma_sel, wr_act, rd_act, tc_act, ref_act, dack_idle;
   logic room, push, f_valid, f_ready;
   logic [ADDR_W+DATA_W-1:0] f_data;

   // pins gathered for the three-stage synchroniser
   assign pins = {bus.data, bus.chip_select_n, bus.direction, bus.data_strobe_n, bus.read_strobe_n,
                  bus.write_strobe_n, bus.burst_refresh_in_n, bus.terminal_count, bus.dma_acknowledge_n};

   // arbitration clock period in cycles
   assign topr = topr_cycles({i_clock_multiplier_hi_bit, i_clock_multiplier_lo_bit});
   assign tarb = i_slow_arbitration_bit ? {topr, 1'b0} : {1'b0, topr};  // [RULE_08]
   assign first_lim = CNT_W'(11'({tarb, 2'b00}) - 11'd1);
   assign gate_lim = i_gate_timer_length_bit ? GATE_LONG_CYC - CNT_W'(1) : GATE_SHORT_CYC - CNT_W'(1);

   // strobe decode; a dma cycle needs acknowledge low and chip select high
   assign dma_sel = !q.filt[PIN_DACK] && q.filt[PIN_CS];
   assign wr_act = dma_sel && (i_motorola_mode ? (!q.filt[PIN_DS] && !q.filt[PIN_DIR])  // [RULE_11]
                                               : !q.filt[PIN_WR]);                     // [RULE_10]
   assign rd_act = dma_sel && (i_motorola_mode ? (!q.filt[PIN_DS] && q.filt[PIN_DIR])   // [RULE_11]
                                               : !q.filt[PIN_RD]);                     // [RULE_10]
   assign tc_act = q.filt[PIN_TC];
   assign ref_act = !q.filt[PIN_REF];
   assign dack_idle = q.filt[PIN_DACK];

   // write bytes queue up here before reaching the ram
   drh_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(push),
      .o_in_ready(room),
      .i_in_data({q.ptr, q.wdat}),
      .o_out_valid(f_valid),
      .i_out_ready(f_ready),
      .o_out_data(f_data)
   );

   // host writes take the ram port first and stall the drain
   assign f_ready = !i_host_we;

   // next-state logic
   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // a bit changes once the second and third stages agree
      n.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
      n.done = 1'b0;
      push = 1'b0;
      case (q.st)
         DEV_IDLE: begin
            n.req = 1'b0;
         end
         DEV_ARM: begin
            // count Tarb periods from the pointer write
            if (q.cnt >= first_lim && room) begin
               n.req = 1'b1;  // [RULE_01]
               n.st = DEV_REQ;
            end else if (q.cnt < first_lim) begin
               n.cnt = q.cnt + CNT_W'(1);  // [RULE_01]
            end
         end
         DEV_REQ: begin
            if (wr_act || rd_act) begin
               n.req = 1'b0;  // [RULE_06]
               n.is_wr = wr_act;
               n.end_x = tc_act && wr_act;  // [RULE_07]
               n.dout = ram[q.ptr];  // [RULE_16]
               n.doe = rd_act;
               n.wdat = q.filt[PIN_DATA +: DATA_W];
               n.st = DEV_XFER;
            end
         end
         DEV_XFER: begin
            if (wr_act || rd_act) begin
               n.doe = rd_act;
               if (wr_act) n.wdat = q.filt[PIN_DATA +: DATA_W];
               if (tc_act && wr_act) n.end_x = 1'b1;  // [RULE_07]
            end else begin
               // strobe released: commit the byte; a write waits one cycle so room counts its push
               n.doe = 1'b0;
               push = q.is_wr;  // [RULE_16]
               n.ptr = q.ptr + ADDR_W'(1);  // [RULE_16]
               n.cnt = '0;
               if (q.end_x) begin
                  n.st = DEV_IDLE;  // [RULE_07]
                  n.done = 1'b1;
               end else if (!i_burst_mode && room && !q.is_wr) begin
                  n.req = 1'b1;  // [RULE_05]
                  n.st = DEV_REQ;
               end else begin
                  n.st = DEV_WAIT;
               end
            end
         end
         DEV_WAIT: begin
            if (!i_burst_mode) begin
               if (room) begin
                  n.req = 1'b1;  // [RULE_05]
                  n.st = DEV_REQ;
               end
            end else if (ref_act && room) begin
               // refresh only comes while acknowledge is high
               n.req = 1'b1;  // [RULE_03] [RULE_04]
               n.st = DEV_REQ;
            end else if (dack_idle) begin
               if (q.cnt >= gate_lim && room) begin
                  n.req = 1'b1;  // [RULE_02]
                  n.st = DEV_REQ;
               end else if (q.cnt < gate_lim) begin
                  n.cnt = q.cnt + CNT_W'(1);  // [RULE_02]
               end
            end else begin
               n.cnt = '0;
            end
         end
         default: begin
            n.st = DEV_IDLE;
            n.req = 1'b0;
         end
      endcase
      // a pointer write restarts the whole sequence
      if (i_host_ptr_wr) begin
         n.ptr = i_host_ptr;
         n.st = DEV_ARM;  // [RULE_01]
         n.cnt = '0;
         n.req = 1'b0;
         n.end_x = 1'b0;
         n.doe = 1'b0;
      end
      n.active = (n.st != DEV_IDLE);
      n.host_rdata = ram[i_host_addr];
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) q <= DEV_RST;
      else q <= n;
   end

   // ram write port: host first, then queued dma bytes
   always_ff @(posedge i_clk) begin
      if (i_host_we) ram[i_host_addr] <= i_host_wdata;
      else if (f_valid) ram[f_data[DATA_W +: ADDR_W]] <= f_data[DATA_W-1:0];
   end

   // outputs straight from the state register
   assign bus.dma_request = q.req;
   assign bus.dev_data_o = q.dout;
   assign bus.dev_data_oe = q.doe;
   assign o_dma_ptr = q.ptr;
   assign o_host_rdata = q.host_rdata;
   assign o_active = q.active;
   assign o_done = q.done;
endmodule
`default_nettype wire

// ==== rtl/drh_pkg.sv ====
// constants shared by both ends of the dma request handshake
`default_nettype none
package drh_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int XTL_PERIOD_NS = 50;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 11;
   localparam int RAM_DEPTH = 2048;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 10;
   // device pin vector layout after the synchroniser
   localparam int PIN_DACK = 0;
   localparam int PIN_TC = 1;
   localparam int PIN_REF = 2;
   localparam int PIN_WR = 3;
   localparam int PIN_RD = 4;
   localparam int PIN_DS = 5;
   localparam int PIN_DIR = 6;
   localparam int PIN_CS = 7;
   localparam int PIN_DATA = 8;
   localparam int DEV_PIN_W = PIN_DATA + DATA_W;
   localparam logic [DEV_PIN_W-1:0] DEV_PIN_IDLE = {{DATA_W{1'b0}}, 8'hbd};
   localparam int CTL_PIN_REQ = 0;
   localparam int CTL_PIN_W = 1 + DATA_W;
   localparam logic [ADDR_W-1:0] PTR_RESET = 11'h000;
   // times in their own units
   localparam int FIRST_REQ_TARB = 4;
   localparam int CYCLE_TARB = 4;
   localparam int GATE_SHORT_TXTL = 7;
   localparam int GATE_LONG_TXTL = 15;
   localparam int READ_EXTRA_NS = 30;
   localparam int WR_PULSE_NS = 65;
   localparam int RD_PULSE_NS = 100;
   localparam int DACK_SETUP_NS = 30;
   localparam int DACK_HOLD_NS = 5;
   localparam int REFRESH_PULSE_NS = 20;
   localparam int REFRESH_IDLE_TXTL = 3;
   // derived cycle counts, least times rounded up
   localparam logic [CNT_W-1:0] GATE_SHORT_CYC =
      CNT_W'((GATE_SHORT_TXTL * XTL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] GATE_LONG_CYC =
      CNT_W'((GATE_LONG_TXTL * XTL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] READ_EXTRA_CYC = CNT_W'((READ_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_PULSE_CYC = CNT_W'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RD_PULSE_CYC = CNT_W'((RD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] DACK_SETUP_CYC = CNT_W'((DACK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] DACK_HOLD_CYC = CNT_W'((DACK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] REFRESH_PULSE_CYC = CNT_W'((REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] GAP_MIN_CYC = REFRESH_PULSE_CYC +
      CNT_W'((REFRESH_IDLE_TXTL * XTL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // operation clock period in cycles from the two multiplier bits
   function automatic logic [7:0] topr_cycles(input logic [1:0] mult);
      int div;
      div = CLK_PERIOD_NS << ((mult == 2'b11) ? 2 : int'(mult));
      return 8'((XTL_PERIOD_NS + div - 1) / div);
   endfunction
endpackage
`default_nettype wire

// ==== rtl/drh_if.sv ====
// pins between the device and the external dma controller
`default_nettype none
interface drh_if #(parameter int DATA_W = 8);
   logic dma_request;
   logic dma_acknowledge_n;
   logic terminal_count;
   logic burst_refresh_in_n;
   logic write_strobe_n;
   logic read_strobe_n;
   logic data_strobe_n;
   logic direction;
   logic chip_select_n;
   logic [DATA_W-1:0] dev_data_o;
   logic dev_data_oe;
   logic [DATA_W-1:0] ctl_data_o;
   logic ctl_data_oe;
   logic [DATA_W-1:0] data;

   // resolved level of the shared data bus
   assign data = dev_data_oe ? dev_data_o : (ctl_data_oe ? ctl_data_o : '1);

   modport dev (output dma_request, dev_data_o, dev_data_oe,
                input dma_acknowledge_n, terminal_count, burst_refresh_in_n, write_strobe_n,
                read_strobe_n, data_strobe_n, direction, chip_select_n, data);
   modport ctl (input dma_request, data,
                output dma_acknowledge_n, terminal_count, burst_refresh_in_n, write_strobe_n,
                read_strobe_n, data_strobe_n, direction, chip_select_n, ctl_data_o, ctl_data_oe);
endinterface
`default_nettype wire

// ==== rtl/drh_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`default_nettype none
module drh_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   import drh_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } drh_fifo_state_t;

   drh_fifo_state_t q, n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // full when pointers differ only in the wrap bit
   assign o_in_ready = (q.wp ^ q.rp) != {1'b1, {AW{1'b0}}};
   assign o_out_valid = q.wp != q.rp;
   assign o_out_data = mem[q.rp[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // pointer update
   always_comb begin
      n = q;
      if (push) n.wp = q.wp + (AW+1)'(1);
      if (pop) n.rp = q.rp + (AW+1)'(1);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) q <= '0;
      else q <= n;
   end

   // storage, no reset needed
   always_ff @(posedge i_clk) begin
      if (push) mem[q.wp[AW-1:0]] <= i_in_data;
   end
endmodule
`default_nettype wire

// ==== rtl/drh_ctrl_end.sv ====
// external dma controller end: acknowledge, strobes, terminal count
`default_nettype none
module drh_ctrl_end (
   input wire logic i_clk,
   input wire logic i_reset_n,
   drh_if.ctl bus,
   input wire logic i_start,
   input wire logic [drh_pkg::ADDR_W:0] i_count,
   input wire logic i_read,
   input wire logic i_motorola_mode,
   input wire logic i_burst_mode,
   input wire logic i_refresh_en,
   input wire logic i_slow_arbitration_bit,
   input wire logic i_clock_multiplier_hi_bit,
   input wire logic i_clock_multiplier_lo_bit,
   input wire logic i_bus_timing_pin,
   input wire logic i_read_bus_timing_bit,
   input wire logic i_wr_valid,
   input wire logic [drh_pkg::DATA_W-1:0] i_wr_data,
   output logic o_wr_ready,
   output logic [drh_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_busy,
   output logic o_done
);
   import drh_pkg::*;

   typedef enum logic [2:0] {CTL_IDLE, CTL_WREQ, CTL_SETUP, CTL_STRB, CTL_HOLD, CTL_GAP} drh_ctl_st_t;

   typedef struct packed {
      drh_ctl_st_t st;
      logic [CTL_PIN_W-1:0] s1;
      logic [CTL_PIN_W-1:0] s2;
      logic [CTL_PIN_W-1:0] s3;
      logic [CTL_PIN_W-1:0] filt;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] sp;
      logic [ADDR_W:0] remain;
      logic is_read;
      logic dack_n, wr_n, rd_n, ds_n, dir, tc, ref_n, cs_n;
      logic [DATA_W-1:0] dout;
      logic doe;
      logic wr_ready;
      logic [DATA_W-1:0] rd_data;
      logic rd_valid, busy, done;
   } drh_ctl_state_t;

   localparam drh_ctl_state_t CTL_RST = '{st: CTL_IDLE, dack_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, ds_n: 1'b1,
      ref_n: 1'b1, cs_n: 1'b1, default: '0};

   drh_ctl_state_t q, n;
   logic [7:0] topr;
   logic [8:0] tarb;
   logic [CNT_W-1:0] space_lim, pulse_lim;

   // cycle spacing: 4 Tarb, plus 30 ns for reads with the bus timing pin low or the read bus timing bit set
   assign topr = topr_cycles({i_clock_multiplier_hi_bit, i_clock_multiplier_lo_bit});
   assign tarb = i_slow_arbitration_bit ? {topr, 1'b0} : {1'b0, topr};  // [RULE_08]
   assign space_lim = CNT_W'(11'({tarb, 2'b00}) - 11'd1) +
      ((q.is_read && (!i_bus_timing_pin || i_read_bus_timing_bit)) ? READ_EXTRA_CYC : '0);  // [RULE_12] [RULE_13]
   assign pulse_lim = q.is_read ? RD_PULSE_CYC - CNT_W'(1) : WR_PULSE_CYC - CNT_W'(1);

   // next-state logic
   always_comb begin
      n = q;
      n.s1 = {bus.data, bus.dma_request};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
      n.rd_valid = 1'b0;
      n.done = 1'b0;
      n.cs_n = 1'b1;  // [RULE_14]
      case (q.st)
         CTL_IDLE: begin
            if (i_start && i_count != '0) begin
               n.remain = i_count;
               n.is_read = i_read;
               n.busy = 1'b1;
               n.st = CTL_WREQ;
            end
         end
         CTL_WREQ: begin
            if (q.filt[CTL_PIN_REQ] && (q.is_read || (q.wr_ready && i_wr_valid))) begin
               n.dack_n = 1'b0;
               n.dir = i_motorola_mode && q.is_read;  // [RULE_11]
               n.dout = i_wr_data;
               n.doe = !q.is_read;
               n.cnt = '0;
               n.st = CTL_SETUP;
            end
         end
         CTL_SETUP: begin
            n.cnt = q.cnt + CNT_W'(1);
            if (q.cnt >= DACK_SETUP_CYC - CNT_W'(1)) begin
               if (i_motorola_mode) begin
                  n.ds_n = 1'b0;  // [RULE_11]
               end else begin
                  n.wr_n = q.is_read;  // [RULE_10]
                  n.rd_n = !q.is_read;  // [RULE_10]
               end
               n.tc = (q.remain == (ADDR_W+1)'(1));
               n.cnt = '0;
               n.sp = '0;
               n.st = CTL_STRB;
            end
         end
         CTL_STRB: begin
            n.cnt = q.cnt + CNT_W'(1);
            n.sp = q.sp + CNT_W'(1);
            if (q.cnt >= pulse_lim) begin
               n.wr_n = 1'b1;
               n.rd_n = 1'b1;
               n.ds_n = 1'b1;
               n.tc = 1'b0;
               n.rd_data = q.filt[1 +: DATA_W];
               n.cnt = '0;
               n.st = CTL_HOLD;
            end
         end
         CTL_HOLD: begin
            n.cnt = q.cnt + CNT_W'(1);
            n.sp = q.sp + CNT_W'(1);
            if (q.cnt >= DACK_HOLD_CYC - CNT_W'(1)) begin
               n.dack_n = 1'b1;  // [RULE_14]
               n.doe = 1'b0;
               n.rd_valid = q.is_read;
               // refresh pulse starts as acknowledge goes high
               n.ref_n = !(i_burst_mode && i_refresh_en);  // [RULE_04]
               n.cnt = '0;
               n.st = CTL_GAP;
            end
         end
         CTL_GAP: begin
            n.cnt = q.cnt + CNT_W'(1);
            n.sp = q.sp + CNT_W'(1);
            if (q.cnt >= REFRESH_PULSE_CYC - CNT_W'(1)) n.ref_n = 1'b1;
            if (q.sp >= space_lim && q.cnt >= GAP_MIN_CYC - CNT_W'(1)) begin
               n.remain = q.remain - (ADDR_W+1)'(1);  // [RULE_12] [RULE_13]
               if (q.remain == (ADDR_W+1)'(1)) begin
                  n.busy = 1'b0;
                  n.done = 1'b1;
                  n.dir = 1'b0;
                  n.st = CTL_IDLE;
               end else begin
                  n.st = CTL_WREQ;
               end
            end
         end
         default: begin
            n = CTL_RST;
         end
      endcase
      n.wr_ready = (n.st == CTL_WREQ) && !n.is_read && n.filt[CTL_PIN_REQ] && (q.st == CTL_WREQ);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) q <= CTL_RST;
      else q <= n;
   end

   // pin and user outputs straight from the state register
   assign bus.dma_acknowledge_n = q.dack_n;
   assign bus.terminal_count = q.tc;
   assign bus.burst_refresh_in_n = q.ref_n;
   assign bus.write_strobe_n = q.wr_n;
   assign bus.read_strobe_n = q.rd_n;
   assign bus.data_strobe_n = q.ds_n;
   assign bus.direction = q.dir;
   assign bus.chip_select_n = q.cs_n;
   assign bus.ctl_data_o = q.dout;
   assign bus.ctl_data_oe = q.doe;
   assign o_wr_ready = q.wr_ready;
   assign o_rd_data = q.rd_data;
   assign o_rd_valid = q.rd_valid;
   assign o_busy = q.busy;
   assign o_done = q.done;
endmodule
`default_nettype wire

// ==== dv/drh_assertions.sv ====
// pin level checks on the dma request handshake
`default_nettype none
module drh_assertions #(parameter int MIN_GAP = 16) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic dma_request,
   input wire logic dma_acknowledge_n,
   input wire logic terminal_count,
   input wire logic burst_refresh_in_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic data_strobe_n,
   input wire logic direction,
   input wire logic chip_select_n,
   input wire logic dev_data_oe
);
   logic [9:0] gap_q;
   logic wr_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // cycles since the last write strobe start, saturating
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gap_q <= 10'h3ff;
         wr_q <= 1'b1;
      end else begin
         gap_q <= (wr_q && !write_strobe_n) ? 10'h000 : gap_q + 10'(gap_q != 10'h3ff);
         wr_q <= write_strobe_n;
      end
   end
   a_req_wr_drop: assert property (
      $fell(write_strobe_n) |-> ##[1:7] !dma_request) else $error("request held in write");
   a_req_ds_drop: assert property (
      $fell(data_strobe_n) |-> ##[1:7] !dma_request) else $error("request held in strobe");
   a_rd_drives_bus: assert property (
      $fell(read_strobe_n) && !dma_acknowledge_n |-> ##[1:7] dev_data_oe) else $error("no read data");
   a_ds_rd_drives: assert property (
      $fell(data_strobe_n) && direction && !dma_acknowledge_n |-> ##[1:7] dev_data_oe) else $error("no data");
   a_wr_no_drive: assert property (
      (!write_strobe_n || (!data_strobe_n && !direction)) |-> !dev_data_oe) else $error("drive in write");
   a_tc_ends_xfer: assert property (
      $rose(write_strobe_n) && $past(terminal_count) |-> (!dma_request) [*8]) else $error("request after end");
   a_drop_cause: assert property (
      $fell(dma_request) && !dma_acknowledge_n |-> !(write_strobe_n && read_strobe_n && data_strobe_n))
      else $error("request dropped alone");
   a_refresh_idle: assert property (
      !burst_refresh_in_n |-> dma_acknowledge_n) else $error("refresh in ack");
   a_cs_inactive: assert property (
      !dma_acknowledge_n |-> chip_select_n) else $error("select in ack");
   a_wr_spacing: assert property (
      wr_q && !write_strobe_n |-> gap_q >= 10'(MIN_GAP - 1)) else $error("writes too close");
   // main scenarios
   c_wr_end: cover property ($rose(write_strobe_n) && $past(terminal_count));
   c_refresh: cover property ($fell(burst_refresh_in_n));
   c_rd_drive: cover property ($rose(dev_data_oe));
endmodule
`default_nettype wire

// ==== dv/dma_request_handshake_tb_top.sv ====
// self-checking bench joining device end and controller end
`default_nettype none
module dma_request_handshake_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import drh_pkg::*;
   logic i_clk = 0, i_reset_n = 0, ptr_wr = 0, host_we = 0, moto = 0, burst = 0, gtl = 0, slow = 0;
   logic mhi = 1, mlo = 0, start = 0, rd = 0, ref_en = 0, rbt = 0, btp = 1, wr_valid = 0, done_seen = 0;
   logic p_ack = 1, p_req = 0, d_active, d_done, wr_ready, rd_valid, busy;
   logic [ADDR_W-1:0] ptr = 0, d_ptr;
   logic [ADDR_W:0] cnt = 1;
   logic [DATA_W-1:0] wr_data = 0, base = 0, rd_data;
   int n_mismatch = 0, checks = 0, wr_cnt = 0, rd_cnt = 0, gap = 0, last_gap = 0, n;
   int tarb[8] = '{13, 7, 4, 4, 26, 14, 8, 8};
   drh_if #(.DATA_W(DATA_W)) bus ();
   drh_device_end drh_device_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus.dev), .i_host_ptr_wr(ptr_wr),
      .i_host_ptr(ptr), .i_host_we(host_we), .i_host_addr(11'h7ff), .i_host_wdata(8'ha5), .i_motorola_mode(moto),
      .i_burst_mode(burst), .i_gate_timer_length_bit(gtl), .i_slow_arbitration_bit(slow),
      .i_clock_multiplier_hi_bit(mhi), .i_clock_multiplier_lo_bit(mlo), .o_dma_ptr(d_ptr), .o_host_rdata(),
      .o_active(d_active), .o_done(d_done));
   drh_ctrl_end drh_ctrl_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus.ctl), .i_start(start), .i_count(cnt),
      .i_read(rd), .i_motorola_mode(moto), .i_burst_mode(burst), .i_refresh_en(ref_en),
      .i_slow_arbitration_bit(slow), .i_clock_multiplier_hi_bit(mhi), .i_clock_multiplier_lo_bit(mlo),
      .i_bus_timing_pin(btp), .i_read_bus_timing_bit(rbt), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
      .o_wr_ready(wr_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_busy(busy), .o_done());
   drh_assertions drh_assertions_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .dma_request(bus.dma_request),
      .dma_acknowledge_n(bus.dma_acknowledge_n), .terminal_count(bus.terminal_count),
      .burst_refresh_in_n(bus.burst_refresh_in_n), .write_strobe_n(bus.write_strobe_n),
      .read_strobe_n(bus.read_strobe_n), .data_strobe_n(bus.data_strobe_n), .direction(bus.direction),
      .chip_select_n(bus.chip_select_n), .dev_data_oe(bus.dev_data_oe));
   // clock
   always #2 i_clk = ~i_clk;
   // gap from acknowledge release to next request, byte and done counting
   always @(posedge i_clk) begin
      gap <= (bus.dma_acknowledge_n && !p_ack) ? 0 : gap + 1;
      if (bus.dma_request && !p_req) last_gap <= gap;
      p_ack <= bus.dma_acknowledge_n;
      p_req <= bus.dma_request;
      if (d_done === 1'b1) done_seen <= 1'b1;
      if (wr_ready === 1'b1 && wr_valid) wr_cnt <= wr_cnt + 1;
   end
   // write byte supply and read byte compare
   always @(negedge i_clk) begin
      wr_data = base + 8'(wr_cnt * 17);
      if (rd_valid === 1'b1) begin
         check("rd_data", 16'(rd_data), 16'(base + 8'(rd_cnt * 17)));
         rd_cnt++;
      end
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic chk_rst();
      check("rst_req", 16'(bus.dma_request), 16'h0000);
      check("rst_ack", 16'(bus.dma_acknowledge_n), 16'h0001);
      check("rst_ptr", 16'(d_ptr), 16'(PTR_RESET));
      check("rst_busy", 16'({d_active, busy, bus.dev_data_oe}), 16'h0000);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one whole transfer from pointer load to controller idle
   task automatic xfer(input logic m, b, r_en, g, r, input logic [ADDR_W:0] len);
      int k;
      @(negedge i_clk);
      {moto, burst, ref_en, gtl, rd, cnt} = {m, b, r_en, g, r, len};
      if (!r) base = base + 8'h07;
      wr_valid = !r;
      ptr = 11'h040;
      ptr_wr = 1;
      {wr_cnt, rd_cnt, done_seen} = '0;
      @(negedge i_clk);
      ptr_wr = 0;
      repeat (3) @(negedge i_clk);
      start = 1;
      @(negedge i_clk);
      start = 0;
      k = 0;
      while (busy !== 1'b0 && k < 30000) begin
         @(negedge i_clk);
         k++;
      end
      check("busy", 16'(busy), 16'h0000);
      check("ptr", 16'(d_ptr), 16'(11'h040 + len));
      check("dev_done", 16'(done_seen), 16'(!r));
      if (r) check("rd_count", 16'(rd_cnt), 16'(len));
   endtask
   // watchdog
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (5) @(negedge i_clk);
      chk_rst();
      i_reset_n = 1;
      for (int i = 0; i < 8; i++) begin
         @(negedge i_clk);
         {slow, mhi, mlo} = 3'(i);
         ptr_wr = 1;
         @(negedge i_clk);
         ptr_wr = 0;
         n = 0;
         do begin
            @(negedge i_clk);
            n++;
         end while (bus.dma_request !== 1'b1 && n < 300);
         check("first_req", 16'(n >= 4 * tarb[i] && n <= 5 * tarb[i] + 10), 16'h0001);
      end
      {slow, mhi, mlo} = 3'b010;
      xfer(0, 0, 0, 0, 0, 3);
      check("gap_nb", 16'(last_gap < 12), 16'h0001);
      rbt = 1;
      xfer(0, 0, 0, 0, 1, 3);
      {rbt, btp} = 2'b00;
      xfer(1, 0, 0, 0, 0, 3);
      xfer(1, 0, 0, 0, 1, 3);
      xfer(0, 1, 1, 0, 0, 2);
      check("gap_ref", 16'(last_gap < 20), 16'h0001);
      xfer(0, 1, 0, 0, 0, 2);
      check("gap_short", 16'(last_gap >= 88 && last_gap <= 110), 16'h0001);
      xfer(0, 1, 0, 1, 0, 2);
      check("gap_long", 16'(last_gap >= 188 && last_gap <= 210), 16'h0001);
      host_we = 1;
      fork
         xfer(0, 0, 0, 0, 0, 20);
         begin
            repeat (3000) @(negedge i_clk);
            check("stall_busy", 16'(busy), 16'h0001);
            check("stall_req", 16'(bus.dma_request), 16'h0000);
            host_we = 0;
         end
      join
      @(negedge i_clk);
      i_reset_n = 0;
      @(negedge i_clk);
      chk_rst();
      i_reset_n = 1;
      close_out();
   end
endmodule
`default_nettype wire
